/* File: phb_host_end.sv */
// module: host pci interface, initiator, subtractive target and arbiter
`timescale 1ns/1ps
module phb_host_end
	import phb_pkg::*;
#(
	parameter int HALF_DIV = BUS_HALF_DIV,
	parameter int RST_HOLD = RESET_HOLD
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	phb_bus_if.host          b,
	input  wire logic        ini_start,
	input  wire logic        ini_write,
	input  wire logic [31:0] ini_addr,
	input  wire logic [31:0] ini_wdata,
	input  wire logic [3:0]  ini_be_n,
	input  wire logic        serr_enable,
	input  wire logic [31:0] tgt_rdata,
	output logic             ini_done,
	output logic [1:0]       ini_status,
	output logic [31:0]      ini_rdata,
	output logic             tgt_valid,
	output logic             tgt_write,
	output logic [31:0]      tgt_addr,
	output logic [31:0]      tgt_wdata,
	output logic [3:0]       tgt_be_n,
	output logic             nmi,
	output logic [3:0]       irq
);
	phb_ini_e    i_st;
	phb_tgt_e    t_st;
	logic [5:0]  lvl, rise;
	logic        tick;
	logic [7:0]  div_reg, rst_cnt_reg;
	logic        clk_o_reg, sys_rst_reg;
	logic        pend_reg, wr_reg, frame_q_reg, locked_reg;
	logic [31:0] addr_reg, wdata_reg;
	logic [3:0]  be_reg;
	logic [2:0]  icnt_reg, tcnt_reg;
	logic [2:0]  gnt_reg;
	logic [1:0]  last_reg;
	logic [31:0] ad_reg;
	logic [3:0]  cbe_reg;
	logic        frame_reg, irdy_reg, trdy_reg, devsel_reg, stop_reg;
	logic        ad_oe, cbe_oe, frame_oe, irdy_oe, t_oe;
	logic        par_reg, par_oe, serr_reg;

	// round robin choice after the last owner
	function automatic logic [1:0] rr_pick(input logic [2:0] act,
		input logic [1:0] last);
		logic [1:0] idx;
		logic       found;
		idx = last;
		found = 1'b0;
		rr_pick = last;
		for (int i = 1; i <= NREQ; i++) begin
			idx = 2'((int'(last) + i) % NREQ);
			if (act[idx] && !found) begin
				rr_pick = idx;
				found = 1'b1;
			end
		end
	endfunction

	// bus clock, interrupts and serr enter through the synchroniser
	phb_sync3 #(.W(6)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({b.serr_n, b.int_n, b.bus_clock}),
		.level (lvl),
		.rise  (rise)
	);
	assign tick = rise[0] & sys_rst_reg;

	assign b.bus_clock_out = clk_o_reg;
	assign b.sys_reset_n   = sys_rst_reg;
	assign b.gnt_n         = gnt_reg;
	assign b.dev_ad        = ad_reg;
	assign b.dev_ad_oe     = ad_oe;
	assign b.dev_cbe_n     = cbe_reg;
	assign b.dev_cbe_oe    = cbe_oe;
	assign b.dev_frame_n   = frame_reg;
	assign b.dev_frame_oe  = frame_oe;
	assign b.dev_irdy_n    = irdy_reg;
	assign b.dev_irdy_oe   = irdy_oe;
	assign b.dev_trdy_n    = trdy_reg;
	assign b.dev_trdy_oe   = t_oe;
	assign b.dev_devsel_n  = devsel_reg;
	assign b.dev_devsel_oe = t_oe;
	assign b.dev_stop_n    = stop_reg;
	assign b.dev_stop_oe   = t_oe;
	assign b.dev_par       = par_reg;
	assign b.dev_par_oe    = par_oe;
	assign b.dev_serr_oe   = serr_reg;

	// bus clock divider
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg   <= '0;
			clk_o_reg <= 1'b0;
		end else if (div_reg == 8'(HALF_DIV - 1)) begin
			div_reg   <= '0;
			clk_o_reg <= ~clk_o_reg;
		end else begin
			div_reg <= div_reg + 8'h1;
		end
	end

	// system reset held after power good rises
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_cnt_reg <= '0;
			sys_rst_reg <= 1'b0;
		end else if (rst_cnt_reg == 8'(RST_HOLD)) begin
			sys_rst_reg <= 1'b1;
		end else begin
			rst_cnt_reg <= rst_cnt_reg + 8'h1;
		end
	end

	// nmi and interrupt pass-through
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi <= 1'b0;
			irq <= '0;
		end else begin
			nmi <= ~lvl[5];
			irq <= ~lvl[4:1];
		end
	end

	// request capture, set wins over completion
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg  <= 1'b0;
			wr_reg    <= 1'b0;
			addr_reg  <= '0;
			wdata_reg <= '0;
			be_reg    <= '1;
		end else if (ini_start) begin
			pend_reg  <= 1'b1;
			wr_reg    <= ini_write;
			addr_reg  <= ini_addr;
			wdata_reg <= ini_wdata;
			be_reg    <= ini_be_n;
		end else if (ini_done) begin
			pend_reg <= 1'b0;
		end
	end

	// arbiter: grant drops to idle before any new owner
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gnt_reg  <= '1;
			last_reg <= 2'(NREQ - 1);
		end else if (tick) begin
			if (gnt_reg != '1) begin
				if ((b.req_n | gnt_reg) == '1) begin
					gnt_reg <= '1;
				end
			end else if (i_st == I_IDLE && !pend_reg && b.frame_n
				&& b.irdy_n && b.req_n != '1) begin
				gnt_reg  <= ~(3'h1 << rr_pick(~b.req_n, last_reg));
				last_reg <= rr_pick(~b.req_n, last_reg);
			end
		end
	end

	// bus protocol: initiator and subtractive target
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			i_st <= I_IDLE; t_st <= T_IDLE;
			icnt_reg <= '0; tcnt_reg <= '0;
			ad_reg <= '0; cbe_reg <= '1; ad_oe <= 1'b0; cbe_oe <= 1'b0;
			frame_reg <= 1'b1; irdy_reg <= 1'b1; trdy_reg <= 1'b1;
			devsel_reg <= 1'b1; stop_reg <= 1'b1; frame_oe <= 1'b0;
			irdy_oe <= 1'b0; t_oe <= 1'b0; par_reg <= 1'b0;
			par_oe <= 1'b0; serr_reg <= 1'b0; frame_q_reg <= 1'b1;
			locked_reg <= 1'b0; ini_done <= 1'b0; ini_status <= ST_OK;
			ini_rdata <= '0; tgt_valid <= 1'b0; tgt_write <= 1'b0;
			tgt_addr <= '0; tgt_wdata <= '0; tgt_be_n <= '1;
		end else begin
			ini_done  <= 1'b0;
			tgt_valid <= 1'b0;
			if (tick) begin
				par_reg     <= phb_even_par(b.ad, b.cbe_n);
				par_oe      <= ad_oe;
				serr_reg    <= 1'b0;
				frame_q_reg <= b.frame_n;
				case (i_st)
				I_IDLE: begin
					frame_oe <= 1'b0;
					irdy_oe  <= 1'b0;
					if (pend_reg && !ini_done && gnt_reg == '1
						&& b.frame_n && b.irdy_n && t_st == T_IDLE) begin
						ad_reg <= addr_reg; ad_oe <= 1'b1;
						cbe_reg <= wr_reg ? CMD_MEM_WR : CMD_MEM_RD;
						cbe_oe <= 1'b1;
						frame_reg <= 1'b0; frame_oe <= 1'b1;
						irdy_reg <= 1'b1; irdy_oe <= 1'b1;
						icnt_reg <= '0; i_st <= I_ADDR;
					end
				end
				I_ADDR: begin
					frame_reg <= 1'b1; irdy_reg <= 1'b0;
					cbe_reg <= be_reg; ad_reg <= wdata_reg;
					ad_oe <= wr_reg; i_st <= I_DATA;
				end
				I_DATA: begin
					icnt_reg <= icnt_reg + 3'h1;
					if ((!b.trdy_n || !b.stop_n) && !b.devsel_n
						|| !b.stop_n
						|| icnt_reg == 3'(DEVSEL_TIMEOUT - 1)) begin
						ini_status <= !b.trdy_n && !b.devsel_n ? ST_OK
							: !b.stop_n && !b.devsel_n ? ST_RETRY
							: !b.stop_n ? ST_TABORT : ST_MABORT;
						serr_reg <= serr_enable & ~b.stop_n
							& b.devsel_n;
						ini_rdata <= b.ad; ini_done <= 1'b1;
						irdy_reg <= 1'b1; ad_oe <= 1'b0; cbe_oe <= 1'b0;
						i_st <= I_TURN;
					end
				end
				I_TURN: begin
					irdy_oe <= 1'b0; frame_oe <= 1'b0;
					i_st <= I_IDLE;
				end
				default: i_st <= I_IDLE;
				endcase
				case (t_st)
				T_IDLE: begin
					if (b.frame_n && b.lock_n) begin
						locked_reg <= 1'b0;
					end
					if (i_st == I_IDLE && !b.frame_n && frame_q_reg) begin
						tgt_addr  <= b.ad;
						tgt_write <= b.cbe_n[CBE_WR_BIT];
						tcnt_reg  <= '0;
						t_st      <= T_WAIT;
					end
				end
				T_WAIT: begin
					tcnt_reg <= tcnt_reg + 3'h1;
					if (!b.devsel_n) begin
						t_st <= T_SKIP;
					end else if (tcnt_reg == 3'(SUB_TICKS - 1)) begin
						devsel_reg <= 1'b0; t_oe <= 1'b1;
						if (locked_reg && b.lock_n) begin
							stop_reg <= 1'b0; trdy_reg <= 1'b1;
							t_st <= T_END;
						end else begin
							stop_reg <= 1'b1; trdy_reg <= 1'b0;
							ad_reg <= tgt_rdata; ad_oe <= ~tgt_write;
							t_st <= T_DATA;
						end
					end
				end
				T_DATA: begin
					if (!b.irdy_n) begin
						tgt_wdata <= b.ad; tgt_be_n <= b.cbe_n;
						tgt_valid <= 1'b1; locked_reg <= ~b.lock_n;
						devsel_reg <= 1'b1; trdy_reg <= 1'b1;
						ad_oe <= 1'b0; t_st <= T_REL;
					end
				end
				T_END: begin
					devsel_reg <= 1'b1; trdy_reg <= 1'b1;
					stop_reg <= 1'b1; t_st <= T_REL;
				end
				T_REL: begin
					t_oe <= 1'b0; t_st <= T_IDLE;
				end
				T_SKIP: begin
					if (b.frame_n && b.irdy_n) begin
						t_st <= T_IDLE;
					end
				end
				default: t_st <= T_IDLE;
				endcase
			end
		end
	end
endmodule

/* File: phb_pkg.sv */
// package: shared constants and helpers for the pci host interface ends
package phb_pkg;
	localparam int AD_W           = 32;
	localparam int CBE_W          = 4;
	localparam int NREQ           = 3;
	localparam int NINT           = 4;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam int CBE_WR_BIT     = 0;
	localparam int BUS_HALF_DIV   = 4;
	localparam int SUB_TICKS      = 3;
	localparam int DEVSEL_TIMEOUT = 5;
	localparam int RESET_HOLD     = 16;
	localparam logic [1:0] ST_OK     = 2'h0;
	localparam logic [1:0] ST_RETRY  = 2'h1;
	localparam logic [1:0] ST_TABORT = 2'h2;
	localparam logic [1:0] ST_MABORT = 2'h3;

	typedef enum logic [2:0] {
		I_IDLE = 3'h0,
		I_ADDR = 3'h1,
		I_DATA = 3'h3,
		I_TURN = 3'h2
	} phb_ini_e;

	typedef enum logic [2:0] {
		T_IDLE = 3'h0,
		T_WAIT = 3'h1,
		T_DATA = 3'h3,
		T_REL  = 3'h2,
		T_END  = 3'h6,
		T_SKIP = 3'h4
	} phb_tgt_e;

	// parity bit that makes the ones count even
	function automatic logic phb_even_par(input logic [AD_W-1:0] ad,
		input logic [CBE_W-1:0] cbe);
		phb_even_par = ^{ad, cbe};
	endfunction
endpackage

/* File: phb_bus_if.sv */
// interface: shared pci bus wires between host end and agent end
`timescale 1ns/1ps
interface phb_bus_if;
	logic              bus_clock_out;
	logic              bus_clock;
	logic              sys_reset_n;
	logic              bus_reset_n;
	logic [31:0]       dev_ad, agt_ad, ad;
	logic              dev_ad_oe, agt_ad_oe;
	logic [3:0]        dev_cbe_n, agt_cbe_n, cbe_n;
	logic              dev_cbe_oe, agt_cbe_oe;
	logic              dev_frame_n, agt_frame_n, frame_n;
	logic              dev_frame_oe, agt_frame_oe;
	logic              dev_irdy_n, agt_irdy_n, irdy_n;
	logic              dev_irdy_oe, agt_irdy_oe;
	logic              dev_trdy_n, agt_trdy_n, trdy_n;
	logic              dev_trdy_oe, agt_trdy_oe;
	logic              dev_devsel_n, agt_devsel_n, devsel_n;
	logic              dev_devsel_oe, agt_devsel_oe;
	logic              dev_stop_n, agt_stop_n, stop_n;
	logic              dev_stop_oe, agt_stop_oe;
	logic              dev_par, agt_par, par;
	logic              dev_par_oe, agt_par_oe;
	logic              dev_serr_oe, agt_serr_oe, serr_n;
	logic              agt_lock_n, agt_lock_oe, lock_n;
	logic [2:0]        req_n, gnt_n;
	logic [3:0]        int_n;

	// board: clock loop and reset buffer
	assign bus_clock   = bus_clock_out;
	assign bus_reset_n = sys_reset_n;
	// pulled-up shared lines
	assign ad       = dev_ad_oe ? dev_ad : agt_ad_oe ? agt_ad : '1;
	assign cbe_n    = dev_cbe_oe ? dev_cbe_n : agt_cbe_oe ? agt_cbe_n : '1;
	assign frame_n  = dev_frame_oe ? dev_frame_n
		: agt_frame_oe ? agt_frame_n : 1'b1;
	assign irdy_n   = dev_irdy_oe ? dev_irdy_n
		: agt_irdy_oe ? agt_irdy_n : 1'b1;
	assign trdy_n   = dev_trdy_oe ? dev_trdy_n
		: agt_trdy_oe ? agt_trdy_n : 1'b1;
	assign devsel_n = dev_devsel_oe ? dev_devsel_n
		: agt_devsel_oe ? agt_devsel_n : 1'b1;
	assign stop_n   = dev_stop_oe ? dev_stop_n
		: agt_stop_oe ? agt_stop_n : 1'b1;
	assign par      = dev_par_oe ? dev_par : agt_par_oe ? agt_par : 1'b1;
	assign serr_n   = ~(dev_serr_oe | agt_serr_oe);
	assign lock_n   = agt_lock_oe ? agt_lock_n : 1'b1;

	modport host (
		output bus_clock_out, sys_reset_n, gnt_n,
		output dev_ad, dev_ad_oe, dev_cbe_n, dev_cbe_oe,
		output dev_frame_n, dev_frame_oe, dev_irdy_n, dev_irdy_oe,
		output dev_trdy_n, dev_trdy_oe, dev_devsel_n, dev_devsel_oe,
		output dev_stop_n, dev_stop_oe, dev_par, dev_par_oe, dev_serr_oe,
		input  bus_clock, ad, cbe_n, frame_n, irdy_n, trdy_n, devsel_n,
		input  stop_n, serr_n, lock_n, req_n, int_n
	);
	modport agent (
		output req_n, int_n, agt_lock_n, agt_lock_oe,
		output agt_ad, agt_ad_oe, agt_cbe_n, agt_cbe_oe,
		output agt_frame_n, agt_frame_oe, agt_irdy_n, agt_irdy_oe,
		output agt_trdy_n, agt_trdy_oe, agt_devsel_n, agt_devsel_oe,
		output agt_stop_n, agt_stop_oe, agt_par, agt_par_oe, agt_serr_oe,
		input  bus_clock, bus_reset_n, ad, cbe_n, frame_n, irdy_n,
		input  trdy_n, devsel_n, stop_n, gnt_n
	);
endinterface

/* File: phb_sync3.sv */
// module: three-stage input synchroniser with filtered level and rise
`timescale 1ns/1ps
module phb_sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise
);
	logic [W-1:0] s1_reg, s2_reg, s3_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= '1;
			s2_reg <= '1;
			s3_reg <= '1;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// a change counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= '1;
			rise  <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					level[i] <= s3_reg[i];
				end
				rise[i] <= ~level[i] & s2_reg[i] & s3_reg[i];
			end
		end
	end
endmodule

/* File: phb_agent_end.sv */
// module: external pci agent, master on request 0 and decoding target
`timescale 1ns/1ps
module phb_agent_end
	import phb_pkg::*;
#(
	parameter logic [31:0] BASE     = 32'h0001_0000,
	parameter int          SIZE_LOG2 = 12
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	phb_bus_if.agent         b,
	input  wire logic        mst_start,
	input  wire logic        mst_write,
	input  wire logic [31:0] mst_addr,
	input  wire logic [31:0] mst_wdata,
	input  wire logic [3:0]  mst_be_n,
	input  wire logic        lock_req,
	input  wire logic        abort_enable,
	input  wire logic [31:0] tgt_rdata,
	input  wire logic [1:0]  other_req_n,
	input  wire logic [3:0]  irq_in_n,
	output logic             mst_done,
	output logic [1:0]       mst_status,
	output logic [31:0]      mst_rdata,
	output logic             tgt_valid,
	output logic [31:0]      tgt_wdata
);
	phb_ini_e    m_st;
	phb_tgt_e    t_st;
	logic [1:0]  lvl, rise;
	logic        tick, pend_reg, frame_q_reg, twr_reg;
	logic [2:0]  cnt_reg;
	logic [31:0] ad_reg;
	logic [3:0]  cbe_reg;
	logic        frame_reg, irdy_reg, trdy_reg, devsel_reg, stop_reg;
	logic        ad_oe, cbe_oe, frame_oe, irdy_oe, t_oe, par_reg, par_oe;
	logic        lock_reg, lock_oe, req_reg;
	logic [1:0]  oreq_reg;
	logic [3:0]  int_reg;

	phb_sync3 #(.W(2)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({b.bus_reset_n, b.bus_clock}),
		.level (lvl),
		.rise  (rise)
	);
	assign tick = rise[0] & lvl[1];

	assign b.agt_ad        = ad_reg;
	assign b.agt_ad_oe     = ad_oe;
	assign b.agt_cbe_n     = cbe_reg;
	assign b.agt_cbe_oe    = cbe_oe;
	assign b.agt_frame_n   = frame_reg;
	assign b.agt_frame_oe  = frame_oe;
	assign b.agt_irdy_n    = irdy_reg;
	assign b.agt_irdy_oe   = irdy_oe;
	assign b.agt_trdy_n    = trdy_reg;
	assign b.agt_trdy_oe   = t_oe;
	assign b.agt_devsel_n  = devsel_reg;
	assign b.agt_devsel_oe = t_oe;
	assign b.agt_stop_n    = stop_reg;
	assign b.agt_stop_oe   = t_oe;
	assign b.agt_par       = par_reg;
	assign b.agt_par_oe    = par_oe;
	assign b.agt_serr_oe   = 1'b0;
	assign b.agt_lock_n    = lock_reg;
	assign b.agt_lock_oe   = lock_oe;
	assign b.req_n         = {oreq_reg, req_reg};
	assign b.int_n         = int_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oreq_reg <= '1;
			int_reg  <= '1;
			pend_reg <= 1'b0;
		end else begin
			oreq_reg <= other_req_n;
			int_reg  <= irq_in_n;
			if (mst_start) begin
				pend_reg <= 1'b1;
			end else if (mst_done) begin
				pend_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			m_st <= I_IDLE; t_st <= T_IDLE; cnt_reg <= '0;
			ad_reg <= '0; cbe_reg <= '1; ad_oe <= 1'b0; cbe_oe <= 1'b0;
			frame_reg <= 1'b1; irdy_reg <= 1'b1; trdy_reg <= 1'b1;
			devsel_reg <= 1'b1; stop_reg <= 1'b1; frame_oe <= 1'b0;
			irdy_oe <= 1'b0; t_oe <= 1'b0; par_reg <= 1'b0;
			par_oe <= 1'b0; lock_reg <= 1'b1; lock_oe <= 1'b0;
			req_reg <= 1'b1; frame_q_reg <= 1'b1; twr_reg <= 1'b0;
			mst_done <= 1'b0; mst_status <= ST_OK; mst_rdata <= '0;
			tgt_valid <= 1'b0; tgt_wdata <= '0;
		end else begin
			mst_done  <= 1'b0;
			tgt_valid <= 1'b0;
			if (tick) begin
				par_reg     <= phb_even_par(b.ad, b.cbe_n);
				par_oe      <= ad_oe;
				frame_q_reg <= b.frame_n;
				case (m_st)
				I_IDLE: begin
					frame_oe <= 1'b0;
					irdy_oe  <= 1'b0;
					lock_oe  <= 1'b0;
					req_reg  <= ~(pend_reg & ~mst_done);
					if (pend_reg && !mst_done && !b.gnt_n[0] && b.frame_n
						&& b.irdy_n) begin
						ad_reg <= mst_addr; ad_oe <= 1'b1;
						cbe_reg <= mst_write ? CMD_MEM_WR : CMD_MEM_RD;
						cbe_oe <= 1'b1;
						frame_reg <= 1'b0; frame_oe <= 1'b1;
						irdy_reg <= 1'b1; irdy_oe <= 1'b1;
						lock_reg <= ~lock_req; lock_oe <= lock_req;
						req_reg <= 1'b1; cnt_reg <= '0; m_st <= I_ADDR;
					end
				end
				I_ADDR: begin
					frame_reg <= 1'b1; irdy_reg <= 1'b0;
					cbe_reg <= mst_be_n; ad_reg <= mst_wdata;
					ad_oe <= mst_write; m_st <= I_DATA;
				end
				I_DATA: begin
					cnt_reg <= cnt_reg + 3'h1;
					if ((!b.trdy_n || !b.stop_n) && !b.devsel_n
						|| !b.stop_n
						|| cnt_reg == 3'(DEVSEL_TIMEOUT - 1)) begin
						mst_status <= !b.trdy_n && !b.devsel_n ? ST_OK
							: !b.stop_n && !b.devsel_n ? ST_RETRY
							: !b.stop_n ? ST_TABORT : ST_MABORT;
						mst_rdata <= b.ad; mst_done <= 1'b1;
						irdy_reg <= 1'b1; ad_oe <= 1'b0; cbe_oe <= 1'b0;
						m_st <= I_TURN;
					end
				end
				I_TURN: begin
					irdy_oe <= 1'b0; frame_oe <= 1'b0; m_st <= I_IDLE;
				end
				default: m_st <= I_IDLE;
				endcase
				case (t_st)
				T_IDLE: begin
					if (m_st == I_IDLE && !b.frame_n && frame_q_reg
						&& b.ad[31:SIZE_LOG2] == BASE[31:SIZE_LOG2]) begin
						twr_reg <= b.cbe_n[CBE_WR_BIT];
						t_oe <= 1'b1; trdy_reg <= abort_enable;
						devsel_reg <= abort_enable; stop_reg <= ~abort_enable;
						ad_reg <= tgt_rdata; ad_oe <= ~b.cbe_n[CBE_WR_BIT];
						t_st <= T_DATA;
					end
				end
				T_DATA: begin
					if (!stop_reg || !b.irdy_n) begin
						tgt_wdata <= b.ad; tgt_valid <= stop_reg & twr_reg;
						trdy_reg <= 1'b1; devsel_reg <= 1'b1;
						stop_reg <= 1'b1; ad_oe <= 1'b0; t_st <= T_REL;
					end
				end
				T_REL: begin
					t_oe <= 1'b0; t_st <= T_IDLE;
				end
				default: t_st <= T_IDLE;
				endcase
			end
		end
	end
endmodule

/* File: phb_checker.sv */
// checker: protocol assertions on the shared pci wires
`timescale 1ns/1ps
module phb_checker (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        bus_clock,
	input  wire logic [2:0]  gnt_n,
	input  wire logic [2:0]  req_n,
	input  wire logic        dev_ad_oe,
	input  wire logic        agt_ad_oe,
	input  wire logic        dev_frame_oe,
	input  wire logic        dev_irdy_oe,
	input  wire logic        dev_trdy_oe,
	input  wire logic        dev_par_oe,
	input  wire logic        dev_serr_oe,
	input  wire logic        par,
	input  wire logic [31:0] ad,
	input  wire logic [3:0]  cbe_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_one_grant: assert property ($onehot0(~gnt_n))
		else $error("more than one grant low");
	a_grant_gap: assert property (($past(gnt_n) != 3'h7 &&
		gnt_n != 3'h7) |-> gnt_n == $past(gnt_n))
		else $error("grant moved without idle gap");
	a_grant_req: assert property (($past(gnt_n) == 3'h7 &&
		gnt_n != 3'h7) |-> (~gnt_n & req_n) == 3'h0)
		else $error("grant without matching request");
	a_frame_own: assert property (dev_frame_oe |-> gnt_n == 3'h7)
		else $error("host frame while another master granted");
	a_ad_alone: assert property (!(dev_ad_oe && agt_ad_oe))
		else $error("both ends drive ad");
	a_role_split: assert property (!(dev_irdy_oe && dev_trdy_oe))
		else $error("host drives irdy and trdy together");
	a_par_late: assert property ($rose(dev_ad_oe) |-> ##8 dev_par_oe)
		else $error("parity not driven one bus clock after ad");
	a_par_even: assert property ((dev_par_oe && $past(dev_par_oe))
		|-> par == ^{$past(ad, 8), $past(cbe_n, 8)})
		else $error("parity not even");
	a_serr_tick: assert property ($rose(dev_serr_oe)
		|-> dev_serr_oe [*8] ##1 !dev_serr_oe)
		else $error("serr pulse not one bus clock");
	a_clk_period: assert property ($rose(bus_clock)
		|-> ##8 $rose(bus_clock))
		else $error("bus clock period wrong");
endmodule

/* File: phb_tb.sv */
// testbench: host end and agent end joined over the shared bus
`timescale 1ns/1ps
module phb_tb import phb_pkg::*;;
	logic        clk, rst_n, ini_start, ini_write, serr_enable;
	logic [31:0] ini_addr, ini_wdata, h_rdata, ini_rdata, h_addr, h_wdata;
	logic [3:0]  ini_be_n, h_be_n, irq, irq_in_n;
	logic [1:0]  ini_status, mst_status, other_req_n;
	logic        ini_done, h_valid, h_write, nmi, nmi_seen;
	logic        mst_start, mst_write, abort_enable, mst_done, a_valid;
	logic        lock_req;
	logic [31:0] mst_addr, mst_wdata, a_rdata, mst_rdata, a_wdata;
	int          mismatches, checked, cycles, h_hits, a_hits;

	phb_bus_if bus ();
	phb_host_end #(.RST_HOLD(4)) i_phb_host_end (.clk, .rst_n, .b(bus),
		.ini_start, .ini_write, .ini_addr, .ini_wdata, .ini_be_n,
		.serr_enable, .tgt_rdata(h_rdata), .ini_done, .ini_status,
		.ini_rdata, .tgt_valid(h_valid), .tgt_write(h_write),
		.tgt_addr(h_addr), .tgt_wdata(h_wdata), .tgt_be_n(h_be_n),
		.nmi, .irq);
	phb_agent_end i_phb_agent_end (.clk, .rst_n, .b(bus), .mst_start,
		.mst_write, .mst_addr, .mst_wdata, .mst_be_n(4'h0),
		.lock_req, .abort_enable, .tgt_rdata(a_rdata), .other_req_n,
		.irq_in_n, .mst_done, .mst_status, .mst_rdata,
		.tgt_valid(a_valid), .tgt_wdata(a_wdata));
	phb_checker i_phb_checker (.clk, .rst_n, .bus_clock(bus.bus_clock),
		.gnt_n(bus.gnt_n), .req_n(bus.req_n), .dev_ad_oe(bus.dev_ad_oe),
		.agt_ad_oe(bus.agt_ad_oe), .dev_frame_oe(bus.dev_frame_oe),
		.dev_irdy_oe(bus.dev_irdy_oe), .dev_trdy_oe(bus.dev_trdy_oe),
		.dev_par_oe(bus.dev_par_oe), .dev_serr_oe(bus.dev_serr_oe),
		.par(bus.par), .ad(bus.ad), .cbe_n(bus.cbe_n));

	always #50 clk = ~clk;

	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// counts pulses, latches nmi, cuts a hang short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (h_valid)
			h_hits <= h_hits + 1;
		if (a_valid)
			a_hits <= a_hits + 1;
		if (nmi)
			nmi_seen <= 1'b1;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask

	// one transfer started by the host or by the agent
	task automatic op(input logic by_agent, input logic wr,
		input logic [31:0] addr, input logic [31:0] data);
		int n;
		@(negedge clk);
		{ini_write, mst_write} = {wr, wr};
		{ini_addr, mst_addr} = {addr, addr};
		{ini_wdata, mst_wdata} = {data, data};
		{ini_start, mst_start} = {!by_agent, by_agent};
		@(negedge clk);
		{ini_start, mst_start} = 2'b00;
		n = 0;
		while ((by_agent ? mst_done : ini_done) !== 1'b1 && n < 400) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(32'(n < 400), 32'h1);
		repeat (16) @(negedge clk);
	endtask

	task automatic wait_gnt(input logic [2:0] exp);
		int n;
		n = 0;
		while (bus.gnt_n !== exp && n < 200) begin
			@(negedge clk);
			n++;
		end
		check(32'(bus.gnt_n), 32'(exp));
	endtask

	initial begin
		{clk, rst_n, ini_start, mst_start, serr_enable} = 5'h0;
		{ini_write, mst_write, abort_enable, nmi_seen, lock_req} = 5'h0;
		{ini_addr, ini_wdata, mst_addr, mst_wdata} = '0;
		{ini_be_n, other_req_n, irq_in_n} = 10'h0ff;
		{mismatches, checked, cycles, h_hits, a_hits} = '0;
		h_rdata = 32'h5a5a_1234;
		a_rdata = 32'hc3c3_0f0f;
		repeat (8) @(negedge clk);
		check({28'h0, bus.gnt_n, bus.sys_reset_n}, 32'he);
		rst_n = 1'b1;
		// host write then read inside the agent window
		op(1'b0, 1'b1, 32'h0001_0010, 32'hdead_beef);
		check(32'(bus.bus_reset_n), 32'h1);
		check(32'(ini_status), 32'(ST_OK));
		check(a_wdata, 32'hdead_beef);
		check(32'(a_hits), 32'h1);
		op(1'b0, 1'b0, 32'h0001_0ffc, 32'h0);
		check(ini_rdata, 32'hc3c3_0f0f);
		// target abort, serr off then on
		abort_enable = 1'b1;
		op(1'b0, 1'b1, 32'h0001_0020, 32'h1);
		check(32'(ini_status), 32'(ST_TABORT));
		check(32'(nmi_seen), 32'h0);
		serr_enable = 1'b1;
		op(1'b0, 1'b1, 32'h0001_0020, 32'h1);
		check(32'(nmi_seen), 32'h1);
		abort_enable = 1'b0;
		// unclaimed host access
		op(1'b0, 1'b0, 32'h0002_0000, 32'h0);
		check(32'(ini_status), 32'(ST_MABORT));
		// agent transfers taken by the subtractive host target
		op(1'b1, 1'b1, 32'h0003_0040, 32'h1234_5678);
		check(32'(mst_status), 32'(ST_OK));
		check(h_addr, 32'h0003_0040);
		check(h_wdata, 32'h1234_5678);
		check({27'h0, h_write, h_be_n}, 32'h10);
		op(1'b1, 1'b0, 32'h0003_0044, 32'h0);
		check(mst_rdata, 32'h5a5a_1234);
		check(32'(h_hits), 32'h2);
		// locked agent write still taken by the host target
		lock_req = 1'b1;
		op(1'b1, 1'b1, 32'h0003_0048, 32'h0bad_cafe);
		lock_req = 1'b0;
		check(32'(mst_status), 32'(ST_OK));
		check(h_wdata, 32'h0bad_cafe);
		check(32'(h_hits), 32'h3);
		// other masters on request lines 1 and 2
		other_req_n = 2'b10;
		wait_gnt(3'h5);
		other_req_n = 2'b11;
		wait_gnt(3'h7);
		other_req_n = 2'b01;
		wait_gnt(3'h3);
		other_req_n = 2'b11;
		wait_gnt(3'h7);
		// interrupt lines pass through
		irq_in_n = 4'ha;
		repeat (16) @(negedge clk);
		check(32'(irq), 32'h5);
		report_and_stop;
	end
endmodule
